// [core/hmb_pkg.sv]
// What this block does
// (RULE_01) dword 12 holds total buffer size in configured memory pages
// (RULE_02) host puts 16-byte aligned low list address in dword 13 bits 31:4
// (RULE_03) dword 14 holds the upper list address, joined to the low half
// (RULE_04) list is one contiguous region; device reads entry-count address/length pairs
// (RULE_05) dword 15 gives the entry count; device processes exactly that many
// (RULE_06) each entry is 16 bytes; entry n at bytes 16n+15 to 16n
// (RULE_07) entry bits 95:64 hold the region length in pages; 127:96 reserved
// (RULE_08) entry bits 63:0 hold a page-aligned base with zero in-page offset
// (RULE_09) get request returns dword 11 settings in completion dword 0 plus structure
// (RULE_10) structure: size, low address, high address, count, then zeros to 4095
// (RULE_11) reported list address has its lowest four bits forced to zero
// (RULE_12) host memory is touched only while the enable bit is one
// (RULE_13) dword 11 bit 1 marks returned buffer; zero means undefined content
// (RULE_14) host leaves buffer, size and list untouched until disabled again
// (RULE_15) device latches size, address and count for later get responses
package hmb_pkg;

	// ************************************************************
	// register map, byte addresses on the apb bus
	// ************************************************************
	localparam logic [7:0] OFS_CDW11 = 8'h00;
	localparam logic [7:0] OFS_CDW12 = 8'h04;
	localparam logic [7:0] OFS_CDW13 = 8'h08;
	localparam logic [7:0] OFS_CDW14 = 8'h0c;
	localparam logic [7:0] OFS_CDW15 = 8'h10;
	localparam logic [7:0] OFS_CMD = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_COMPL_DW0 = 8'h1c;
	localparam logic [7:0] OFS_BUF_LOW = 8'h20;
	localparam logic [7:0] OFS_BUF_HIGH = 8'h24;
	localparam logic [7:0] OFS_PAGE_SIZE = 8'h28;
	localparam logic [7:0] OFS_TOTAL_PAGES = 8'h2c;
	localparam logic [7:0] OFS_ENTRIES_DONE = 8'h30;

	// ************************************************************
	// field positions and reset values
	// ************************************************************
	localparam int BUFFER_ENABLE_BIT = 0;
	localparam int BUFFER_RETURNED_BIT = 1;
	localparam int CMD_SET_BIT = 0;
	localparam int CMD_GET_BIT = 1;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_ALIGN_ERR_BIT = 2;
	localparam int ST_ENABLED_BIT = 3;
	localparam int ST_RETURNED_BIT = 4;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [3:0] RESET_PAGE_SIZE = 4'h0;

	// ************************************************************
	// structure sizes
	// ************************************************************
	localparam int PAGE_SHIFT_BASE = 12;
	localparam logic [31:0] LIST_ALIGN_MASK = 32'hffff_fff0;
	localparam logic [63:0] ENTRY_STRIDE = 64'h0000_0000_0000_0010;
	localparam logic [63:0] DWORD_STRIDE = 64'h0000_0000_0000_0004;
	localparam int ATTR_DWORDS = 1024;
	localparam int ATTR_IDX_W = 10;
	localparam int LEN_LSB = 64;
	localparam int LEN_MSB = 95;

	typedef enum logic [1:0] {PH_IDLE, PH_ENTRY_REQ, PH_ENTRY_WAIT, PH_ATTR_WR} phase_type;

endpackage

// [core/desc_if.sv]
`timescale 1ns/1ps
// one descriptor entry fetch between walker and reader
interface desc_if;
	logic start;
	logic [63:0] addr;
	logic done;
	logic [127:0] entry;
	modport walker (output start, output addr, input done, input entry);
	modport reader (input start, input addr, output done, output entry);
endinterface

// [core/desc_fetch.sv]
`timescale 1ns/1ps
module desc_fetch
	import hmb_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// entry request from the walker
	desc_if.reader dif,
	// dword reads of host memory
	output logic mem_rd_req,
	output logic [63:0] mem_rd_addr,
	input wire logic mem_rd_ack,
	input wire logic [31:0] mem_rd_data
);

	typedef struct packed {
		logic busy;
		logic [1:0] idx;
		logic [63:0] addr;
		logic [127:0] entry;
		logic done;
	} fetch_state_type;

	fetch_state_type state;
	fetch_state_type next_state;

	// ************************************************************
	// four dword reads make one entry, low dword first
	// ************************************************************
	always_comb begin
		next_state = state;
		next_state.done = 1'b0;
		if (!state.busy && dif.start) begin
			next_state.busy = 1'b1;
			next_state.idx = 2'd0;
			next_state.addr = dif.addr; // RULE_04
		end else if (state.busy && mem_rd_ack) begin
			next_state.entry[state.idx*32 +: 32] = mem_rd_data; // RULE_06
			next_state.addr = state.addr + DWORD_STRIDE;
			next_state.idx = state.idx + 2'd1;
			if (state.idx == 2'd3) begin
				next_state.busy = 1'b0;
				next_state.done = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			next_state_reset: state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign mem_rd_req = state.busy;
	assign mem_rd_addr = state.addr;
	assign dif.done = state.done;
	assign dif.entry = state.entry;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_req_held: assert property (mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr)) // RULE_04
		else $error("read request dropped or moved before acknowledge");
	a_entry_four: assert property ($rose(mem_rd_req) |-> ##[4:1000] dif.done) // RULE_06
		else $error("entry fetch did not finish after four dwords");

endmodule

// [core/hmb_setup.sv]
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
module hmb_setup
	import hmb_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// apb register slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// descriptor reads from host memory
	output logic mem_rd_req,
	output logic [63:0] mem_rd_addr,
	input wire logic mem_rd_ack,
	input wire logic [31:0] mem_rd_data,
	// attributes structure into the command data buffer
	output logic buf_wr_valid,
	output logic [63:0] buf_wr_addr,
	output logic [31:0] buf_wr_data,
	input wire logic buf_wr_ready,
	// buffer state
	output logic buffer_in_use
);

	typedef struct packed {
		logic [31:0] cdw11;
		logic [31:0] cdw12;
		logic [31:0] cdw13;
		logic [31:0] cdw14;
		logic [31:0] cdw15;
		logic [63:0] buf_base;
		logic [3:0] configured_page_size;
		logic [31:0] size;
		logic [31:0] desc_list_addr_low;
		logic [31:0] desc_list_addr_high;
		logic [31:0] desc_entry_count;
		logic enable;
		logic returned;
		phase_type phase;
		logic [31:0] idx;
		logic [31:0] total;
		logic [63:0] ptr;
		logic align_err;
		logic done;
		logic start;
		logic [31:0] compl_dw0;
		logic [31:0] rdata;
		logic [31:0] wdata;
		logic [63:0] waddr;
		logic [ATTR_IDX_W-1:0] widx;
	} top_state_type;

	top_state_type state;
	top_state_type next_state;
	desc_if dif();
	logic set_go;
	logic get_go;
	logic wr_acc;
	logic [63:0] page_mask;

	// ************************************************************
	// attributes structure word by dword index
	// ************************************************************
	function automatic logic [31:0] attr_word(input top_state_type s,
			input logic [ATTR_IDX_W-1:0] i);
		case (i)
			10'd0: attr_word = s.size; // RULE_10
			10'd1: attr_word = s.desc_list_addr_low & LIST_ALIGN_MASK; // RULE_11
			10'd2: attr_word = s.desc_list_addr_high;
			10'd3: attr_word = s.desc_entry_count;
			default: attr_word = RESET_WORD; // RULE_10
		endcase
	endfunction

	// read mux, sampled in the setup cycle so prdata is a flop
	function automatic logic [31:0] read_word(input top_state_type s, input logic [7:0] a);
		case (a)
			OFS_CDW11: read_word = s.cdw11;
			OFS_CDW12: read_word = s.cdw12;
			OFS_CDW13: read_word = s.cdw13;
			OFS_CDW14: read_word = s.cdw14;
			OFS_CDW15: read_word = s.cdw15;
			OFS_STATUS: begin
				read_word = RESET_WORD;
				read_word[ST_BUSY_BIT] = (s.phase != PH_IDLE);
				read_word[ST_DONE_BIT] = s.done;
				read_word[ST_ALIGN_ERR_BIT] = s.align_err;
				read_word[ST_ENABLED_BIT] = s.enable;
				read_word[ST_RETURNED_BIT] = s.returned;
			end
			OFS_COMPL_DW0: read_word = s.compl_dw0;
			OFS_BUF_LOW: read_word = s.buf_base[31:0];
			OFS_BUF_HIGH: read_word = s.buf_base[63:32];
			OFS_PAGE_SIZE: read_word = {28'h0, s.configured_page_size};
			OFS_TOTAL_PAGES: read_word = s.total;
			OFS_ENTRIES_DONE: read_word = s.idx;
			default: read_word = RESET_WORD;
		endcase
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'b00) && (a <= OFS_ENTRIES_DONE);
	endfunction

	// in-page offset bits for the configured page size
	assign page_mask = (64'h1 << (PAGE_SHIFT_BASE + int'(state.configured_page_size))) - 64'h1;

	// ************************************************************
	// register writes, command launch and the walk
	// ************************************************************
	always_comb begin
		next_state = state;
		next_state.start = 1'b0;
		wr_acc = psel && penable && pwrite && mapped(paddr);
		set_go = 1'b0;
		get_go = 1'b0;
		if (psel && !penable) begin
			next_state.rdata = read_word(state, paddr);
		end
		// configuration only moves while idle so a running walk sees stable values
		if (wr_acc && state.phase == PH_IDLE) begin
			case (paddr)
				OFS_CDW11: next_state.cdw11 = pwdata;
				OFS_CDW12: next_state.cdw12 = pwdata; // RULE_01
				OFS_CDW13: next_state.cdw13 = pwdata;
				OFS_CDW14: next_state.cdw14 = pwdata; // RULE_03
				OFS_CDW15: next_state.cdw15 = pwdata; // RULE_05
				OFS_BUF_LOW: next_state.buf_base[31:0] = pwdata;
				OFS_BUF_HIGH: next_state.buf_base[63:32] = pwdata;
				OFS_PAGE_SIZE: next_state.configured_page_size = pwdata[3:0];
				OFS_CMD: begin
					set_go = pwdata[CMD_SET_BIT];
					get_go = pwdata[CMD_GET_BIT] && !pwdata[CMD_SET_BIT];
				end
				default: ;
			endcase
		end
		// done clears by writing one; a completion in the same cycle wins below
		if (wr_acc && paddr == OFS_STATUS && pwdata[ST_DONE_BIT]) begin
			next_state.done = 1'b0;
		end
		if (set_go) begin
			next_state.size = state.cdw12; // RULE_15
			next_state.desc_list_addr_low = state.cdw13;
			next_state.desc_list_addr_high = state.cdw14;
			next_state.desc_entry_count = state.cdw15;
			next_state.enable = state.cdw11[BUFFER_ENABLE_BIT];
			next_state.returned = state.cdw11[BUFFER_RETURNED_BIT]; // RULE_13
			next_state.ptr = {state.cdw14, state.cdw13 & LIST_ALIGN_MASK}; // RULE_03
			next_state.idx = RESET_WORD;
			next_state.total = RESET_WORD;
			next_state.align_err = 1'b0;
			// a disabling request or an empty list completes without any memory access
			if (state.cdw11[BUFFER_ENABLE_BIT] && state.cdw15 != RESET_WORD) begin // RULE_12
				next_state.phase = PH_ENTRY_REQ;
				next_state.done = 1'b0;
			end else begin
				next_state.done = 1'b1;
			end
		end
		if (get_go) begin
			next_state.compl_dw0 = RESET_WORD; // RULE_09
			next_state.compl_dw0[BUFFER_ENABLE_BIT] = state.enable;
			next_state.compl_dw0[BUFFER_RETURNED_BIT] = state.returned;
			next_state.widx = '0;
			next_state.waddr = state.buf_base;
			next_state.wdata = attr_word(state, '0);
			next_state.phase = PH_ATTR_WR;
			next_state.done = 1'b0;
		end
		// phase sequencing
		case (state.phase)
			PH_IDLE: ;
			PH_ENTRY_REQ: begin
				if (state.enable) begin // RULE_12
					next_state.start = 1'b1;
					next_state.phase = PH_ENTRY_WAIT;
				end else begin
					next_state.phase = PH_IDLE;
				end
			end
			PH_ENTRY_WAIT: begin
				if (dif.done) begin
					// the host owes page alignment; a slip is flagged, not fatal
					if ((dif.entry[63:0] & page_mask) != 64'h0) begin // RULE_08
						next_state.align_err = 1'b1;
					end
					next_state.total = state.total + dif.entry[LEN_MSB:LEN_LSB]; // RULE_07
					next_state.idx = state.idx + 32'h1;
					next_state.ptr = state.ptr + ENTRY_STRIDE; // RULE_06
					if (state.idx + 32'h1 == state.desc_entry_count) begin // RULE_05
						next_state.phase = PH_IDLE;
						next_state.done = 1'b1;
					end else begin
						next_state.phase = PH_ENTRY_REQ;
					end
				end
			end
			PH_ATTR_WR: begin
				if (buf_wr_ready) begin
					if (state.widx == ATTR_IDX_W'(ATTR_DWORDS - 1)) begin // RULE_10
						next_state.phase = PH_IDLE;
						next_state.done = 1'b1;
					end else begin
						next_state.widx = state.widx + 1'b1;
						next_state.waddr = state.waddr + DWORD_STRIDE;
						next_state.wdata = attr_word(state, state.widx + 1'b1);
					end
				end
			end
			default: next_state.phase = PH_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= '0;
			state.configured_page_size <= RESET_PAGE_SIZE;
			state.phase <= PH_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ************************************************************
	// entry reader and outputs
	// ************************************************************
	assign dif.start = state.start;
	assign dif.addr = state.ptr; // RULE_04

	desc_fetch u_fetch (
		.core_clk(core_clk),
		.rst(rst),
		.dif(dif),
		.mem_rd_req(mem_rd_req),
		.mem_rd_addr(mem_rd_addr),
		.mem_rd_ack(mem_rd_ack),
		.mem_rd_data(mem_rd_data)
	);

	// zero wait states: the access phase always completes
	assign pready = psel && penable;
	assign pslverr = psel && penable && !mapped(paddr);
	assign prdata = state.rdata;
	assign buf_wr_valid = (state.phase == PH_ATTR_WR);
	assign buf_wr_addr = state.waddr;
	assign buf_wr_data = state.wdata;
	assign buffer_in_use = state.enable;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_no_access_off: assert property (mem_rd_req |-> state.enable) // RULE_12
		else $error("host memory read while buffer disabled");
	a_latch_set: assert property (set_go |=> state.size == $past(state.cdw12)
			&& state.desc_entry_count == $past(state.cdw15)) // RULE_15
		else $error("set request fields not latched");
	a_addr_join: assert property (set_go |=> state.ptr[63:32] == $past(state.cdw14)
			&& state.ptr[3:0] == 4'h0) // RULE_03
		else $error("list address not joined from both dwords");
	a_entry_count: assert property (state.phase == PH_ENTRY_WAIT && dif.done
			&& next_state.phase == PH_IDLE |=> state.idx == state.desc_entry_count) // RULE_05
		else $error("walk ended at wrong entry count");
	a_list_stride: assert property (state.phase == PH_ENTRY_WAIT && dif.done
			|=> state.ptr == $past(state.ptr) + ENTRY_STRIDE) // RULE_06
		else $error("next entry not sixteen bytes on");
	a_total_pages: assert property (state.phase == PH_ENTRY_WAIT && dif.done
			|=> state.total == $past(state.total) + $past(dif.entry[LEN_MSB:LEN_LSB])) // RULE_07
		else $error("entry length not summed");
	a_compl_dword: assert property (get_go |=> state.compl_dw0[1:0]
			== {state.returned, state.enable}) // RULE_09
		else $error("completion dword 0 wrong");
	a_attr_size: assert property (buf_wr_valid && state.widx == '0 |-> buf_wr_data == state.size) // RULE_10
		else $error("structure word 0 is not the size");
	a_attr_align: assert property (buf_wr_valid && state.widx == 10'd1
			|-> buf_wr_data[3:0] == 4'h0) // RULE_11
		else $error("reported list address not aligned");
	a_attr_zero: assert property (buf_wr_valid && state.widx > 10'd3 |-> buf_wr_data == 32'h0) // RULE_10
		else $error("reserved structure word not zero");

endmodule

// [test/host_mem_model.sv]
`timescale 1ns/1ps
// ****************
// host memory and data buffer
// ****************
module host_mem_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// stall control from the bench
	input wire logic slow,
	// descriptor reads
	input wire logic mem_rd_req,
	input wire logic [63:0] mem_rd_addr,
	output logic mem_rd_ack,
	output logic [31:0] mem_rd_data,
	// attribute writes
	input wire logic buf_wr_valid,
	input wire logic [63:0] buf_wr_addr,
	input wire logic [31:0] buf_wr_data,
	output logic buf_wr_ready
);
	logic [31:0] mem [logic [63:0]];
	logic [31:0] got [logic [63:0]];
	int rd_count = 0;
	int stray = 0;
	int wr_count = 0;
	logic [1:0] gap = 2'h0;
	initial mem_rd_ack = 1'b0;
	initial mem_rd_data = 32'h0;
	initial buf_wr_ready = 1'b0;
	// the list is one aligned block, filled before and left alone during a walk
	task automatic put(input logic [63:0] a, input logic [31:0] d);
		mem[a] = d;
	endtask
	// one dword per ack pulse; idle data is inverted so stale values never match
	always @(posedge core_clk) begin
		if (rst) begin
			mem_rd_ack <= 1'b0;
			buf_wr_ready <= 1'b0;
		end else begin
			gap <= gap + 2'h1;
			if (mem_rd_req && !mem_rd_ack && (!slow || gap == 2'h3)) begin
				mem_rd_ack <= 1'b1;
				rd_count++;
				if (mem.exists(mem_rd_addr)) begin
					mem_rd_data <= mem[mem_rd_addr];
				end else begin
					stray++;
					mem_rd_data <= ~mem_rd_data;
				end
			end else begin
				mem_rd_ack <= 1'b0;
				mem_rd_data <= ~mem_rd_data;
			end
			buf_wr_ready <= slow ? ~buf_wr_ready : 1'b1;
			if (buf_wr_valid && buf_wr_ready) begin
				got[buf_wr_addr] = buf_wr_data;
				wr_count++;
			end
		end
	end
endmodule

// [test/tb_host_memory_buffer_setup.sv]
`timescale 1ns/1ps
// ****************
// bench for the buffer setup block
// ****************
module tb_host_memory_buffer_setup;
	import hmb_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic pready, pslverr, mem_rd_req, mem_rd_ack, buf_wr_valid, buf_wr_ready, buffer_in_use;
	logic [31:0] prdata, mem_rd_data, buf_wr_data, rdv, ex;
	logic [63:0] mem_rd_addr, buf_wr_addr;
	logic slow = 1'b0;
	logic erv;
	int n_fail = 0;
	int cmp_count = 0;
	localparam logic [31:0] LIST_L = 32'h1000_0008;
	localparam logic [31:0] LIST_H = 32'h0000_0001;
	localparam logic [63:0] LIST = 64'h0000_0001_1000_0000;
	logic [63:0] eb [4] = '{64'h2_0000_0000, 64'h2_0000_4000, 64'h2_0000_7000, 64'h2_0001_0000};
	logic [31:0] el [4] = '{32'h2, 32'h5, 32'h7, 32'h100};

	always #12.5 core_clk = ~core_clk;

	hmb_setup dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
		.mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data), .buf_wr_valid(buf_wr_valid),
		.buf_wr_addr(buf_wr_addr), .buf_wr_data(buf_wr_data), .buf_wr_ready(buf_wr_ready),
		.buffer_in_use(buffer_in_use));

	host_mem_model host (.core_clk(core_clk), .rst(rst), .slow(slow),
		.mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack),
		.mem_rd_data(mem_rd_data), .buf_wr_valid(buf_wr_valid), .buf_wr_addr(buf_wr_addr),
		.buf_wr_data(buf_wr_data), .buf_wr_ready(buf_wr_ready));

	// ****************
	// shared tasks
	// ****************
	// apb transfer: setup cycle, then access held until pready is seen at an edge
	// no cycle count is assumed; a slave that never answers is left to the watchdog
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// poll for done under a bound, then clear it
	task automatic wait_done;
		int k;
		rdv = 32'h0;
		for (k = 0; k < 3000 && rdv[ST_DONE_BIT] !== 1'b1; k++) begin
			apb(OFS_STATUS, 1'b0, 32'h0);
		end
		chk({31'h0, rdv[ST_DONE_BIT]}, 32'h1);
		apb(OFS_STATUS, 1'b1, 32'h2);
	endtask

	task automatic report_and_stop;
		$display("compares=%0d mismatches=%0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// watchdog: the whole run needs well under ten thousand cycles
	initial begin
		repeat (40000) @(posedge core_clk);
		n_fail++;
		report_and_stop();
	end

	// ****************
	// test sequence
	// ****************
	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		apb(OFS_STATUS, 1'b0, 32'h0);
		chk(rdv, RESET_WORD);
		apb(8'h34, 1'b0, 32'h0);
		chk({rdv[30:0], erv}, 32'h1);
		// three entries, a fourth that must not be read, reserved dword set
		for (int i = 0; i < 4; i++) begin
			host.put(LIST + 16 * i, eb[i][31:0]);
			host.put(LIST + 16 * i + 4, eb[i][63:32]);
			host.put(LIST + 16 * i + 8, el[i]);
			host.put(LIST + 16 * i + 12, 32'hffff_ffff);
		end
		apb(OFS_PAGE_SIZE, 1'b1, 32'h1);
		apb(OFS_CDW11, 1'b1, 32'h1);
		apb(OFS_CDW12, 1'b1, 32'he);
		apb(OFS_CDW13, 1'b1, LIST_L);
		apb(OFS_CDW14, 1'b1, LIST_H);
		apb(OFS_CDW15, 1'b1, 32'h3);
		// reads acknowledged one in four cycles so the fetch must hold its request
		slow <= 1'b1;
		apb(OFS_CMD, 1'b1, 32'h1);
		wait_done();
		chk(32'(host.rd_count), 32'hc);
		chk(32'(host.stray), 32'h0);
		apb(OFS_TOTAL_PAGES, 1'b0, 32'h0);
		chk(rdv, 32'he);
		apb(OFS_ENTRIES_DONE, 1'b0, 32'h0);
		chk(rdv, 32'h3);
		apb(OFS_STATUS, 1'b0, 32'h0);
		chk(rdv & 32'h1c, 32'hc);
		chk({31'h0, buffer_in_use}, 32'h1);
		// attributes structure with the buffer stalling every other cycle
		slow <= 1'b1;
		apb(OFS_BUF_LOW, 1'b1, 32'h3000);
		apb(OFS_BUF_HIGH, 1'b1, 32'h0);
		apb(OFS_CMD, 1'b1, 32'h2);
		wait_done();
		for (int i = 0; i < 1024; i++) begin
			ex = i == 0 ? 32'he : i == 1 ? (LIST_L & 32'hffff_fff0) : i == 2 ? LIST_H :
				i == 3 ? 32'h3 : 32'h0;
			rdv = host.got.exists(64'h3000 + 4 * i) ? host.got[64'h3000 + 4 * i] : 32'hx;
			chk(rdv, ex);
		end
		chk(32'(host.wr_count), 32'h400);
		apb(OFS_COMPL_DW0, 1'b0, 32'h0);
		chk(rdv, 32'h1);
		// returned memory with enable clear: no host access at all
		slow <= 1'b0;
		apb(OFS_CDW11, 1'b1, 32'h2);
		// both command bits at once: the set wins and no structure is written
		apb(OFS_CMD, 1'b1, 32'h3);
		wait_done();
		chk(32'(host.wr_count), 32'h400);
		apb(OFS_COMPL_DW0, 1'b0, 32'h0);
		chk(rdv, 32'h1);
		chk(32'(host.rd_count), 32'hc);
		chk({31'h0, buffer_in_use}, 32'h0);
		apb(OFS_STATUS, 1'b0, 32'h0);
		chk(rdv & 32'h18, 32'h10);
		apb(OFS_CMD, 1'b1, 32'h2);
		wait_done();
		apb(OFS_COMPL_DW0, 1'b0, 32'h0);
		chk(rdv, 32'h2);
		report_and_stop();
	end
endmodule
